//--- src/rtc_chain.sv
// Real time clock: clock select, prescalers, prescale timer, 32-bit count
`timescale 1ns/1ps
module rtc_chain
    import rtc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic int_tick0,
    input wire logic int_tick1,
    input wire logic [rtc_pkg::RTC_NPIN-1:0] clk_pin,
    input wire rtc_pkg::rtc_cfg_s cfg,
    input wire rtc_pkg::rtc_wr_s wr,
    output logic [rtc_pkg::RTC_PRE_W-1:0] prescale_timer,
    output logic [rtc_pkg::RTC_HALF_W-1:0] count_high_word,
    output logic [rtc_pkg::RTC_HALF_W-1:0] count_low_word,
    output logic [rtc_pkg::RTC_NREQ-1:0] stage_req_q,
    output logic irq_q
);
    import rtc_pkg::*;

    logic [RTC_NPIN-1:0] pin_s1_q;
    logic [RTC_NPIN-1:0] pin_s2_q;
    logic [RTC_NPIN-1:0] pin_s3_q;
    logic [RTC_NPIN-1:0] pin_rise;
    logic src_tick;
    logic [RTC_DIV32_W-1:0] div32_q;
    logic [RTC_DIV8_W-1:0] div8_q;
    logic div32_tick;
    logic div8_tick;
    logic [RTC_S0_W-1:0] s0_q;
    logic [RTC_S1_W-1:0] s1_q;
    logic [RTC_S2_W-1:0] s2_q;
    logic [RTC_S3_W-1:0] s3_q;
    logic pre_ovf;
    logic s0_ovf;
    logic s1_ovf;
    logic s2_ovf;
    logic s3_ovf;
    logic [RTC_CNT_W-1:0] count_all;
    logic [RTC_CNT_W-1:0] wr_word;
    logic alarm_hit;
    logic [RTC_S0_W-1:0] s0_nx;
    logic [RTC_S1_W-1:0] s1_nx;
    logic [RTC_S2_W-1:0] s2_nx;
    logic [RTC_S3_W-1:0] s3_nx;
    logic [RTC_NREQ-1:0] req_now;

    // Two-flop synchronisers and a third flop for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < RTC_NPIN; gi++) begin : g_pin
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                    pin_s3_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    pin_s1_q[gi] <= clk_pin[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                end
            end
            assign pin_rise[gi] = pin_s2_q[gi] & ~pin_s3_q[gi];
        end
    endgenerate

    // Counting source select
    assign src_tick = (cfg.src_sel == RTC_SRC_INT0) ? int_tick0 :
                      (cfg.src_sel == RTC_SRC_INT1) ? int_tick1 :
                      (cfg.src_sel == RTC_SRC_PIN0) ? pin_rise[0] : pin_rise[1];

    // Fixed prescalers, each bypassed when switched off
    assign div32_tick = cfg.div32_on ? (src_tick & (&div32_q)) : src_tick;
    assign div8_tick = cfg.div8_on ? (div32_tick & (&div8_q)) : div32_tick;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div32_q <= RTC_DIV32_RST;
        end else if (clk_en && cfg.div32_on && src_tick) begin
            div32_q <= div32_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div8_q <= RTC_DIV8_RST;
        end else if (clk_en && cfg.div8_on && div32_tick) begin
            div8_q <= div8_q + 3'h1;
        end
    end

    // Write word for the count halves
    assign wr_word = {wr.wdata, wr.wdata};

    // Serial chain: prescale timer, then four sub-timers
    rtc_stage #(.W(RTC_PRE_W)) u_pre (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_in(div8_tick),
        .reload(cfg.pre_reload),
        .wr(wr.wr_pre),
        .wdata(wr.wdata),
        .cnt_q(prescale_timer),
        .ovf(pre_ovf)
    );

    rtc_stage #(.W(RTC_S0_W)) u_s0 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_in(pre_ovf),
        .reload(cfg.s0_reload),
        .wr(wr.wr_low),
        .wdata(wr_word[9:0]),
        .cnt_q(s0_q),
        .ovf(s0_ovf)
    );

    rtc_stage #(.W(RTC_S1_W)) u_s1 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_in(s0_ovf),
        .reload(cfg.s1_reload),
        .wr(wr.wr_low),
        .wdata(wr_word[15:10]),
        .cnt_q(s1_q),
        .ovf(s1_ovf)
    );

    rtc_stage #(.W(RTC_S2_W)) u_s2 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_in(s1_ovf),
        .reload(cfg.s2_reload),
        .wr(wr.wr_high),
        .wdata(wr_word[21:16]),
        .cnt_q(s2_q),
        .ovf(s2_ovf)
    );

    rtc_stage #(.W(RTC_S3_W)) u_s3 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_in(s2_ovf),
        .reload(cfg.s3_reload),
        .wr(wr.wr_high),
        .wdata(wr_word[31:22]),
        .cnt_q(s3_q),
        .ovf(s3_ovf)
    );

    // Count halves as seen by software; 48 bits with the prescale timer
    assign count_all = {s3_q, s2_q, s1_q, s0_q};
    assign count_high_word = count_all[31:16];
    assign count_low_word = count_all[15:0];

    // Value the count takes at this tick; reloaded stages do not wrap to zero
    assign s0_nx = s0_ovf ? cfg.s0_reload : s0_q + 10'h001;
    assign s1_nx = s1_ovf ? cfg.s1_reload : s1_q + {5'h00, s0_ovf};
    assign s2_nx = s2_ovf ? cfg.s2_reload : s2_q + {5'h00, s1_ovf};
    assign s3_nx = s3_ovf ? cfg.s3_reload : s3_q + {9'h000, s2_ovf};

    // Alarm fires when the count steps onto the programmed value
    assign alarm_hit = pre_ovf && ({s3_nx, s2_nx, s1_nx, s0_nx} == cfg.alarm_value);

    // Per-stage requests and the merged line
    assign req_now = {alarm_hit, s3_ovf, s2_ovf, s1_ovf, s0_ovf, pre_ovf};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage_req_q <= RTC_REQ_RST;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            stage_req_q <= req_now;
            irq_q <= |(req_now & cfg.irq_en);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    pre_reload_a: assert property (clk_en && pre_ovf && !wr.wr_pre |=> prescale_timer == $past(cfg.pre_reload))
        else $error("prescale timer did not reload on overflow");
    pre_up_a: assert property (clk_en && div8_tick && !pre_ovf && !wr.wr_pre |=> prescale_timer == $past(prescale_timer) + 16'h0001)
        else $error("prescale timer did not count up by one");
    chain_step_a: assert property (clk_en && s0_ovf && !s1_ovf && !wr.wr_low |=> s1_q == $past(s1_q) + 6'h01)
        else $error("overflow did not advance the next stage");
    hold_idle_a: assert property (!div8_tick && !wr.wr_pre |=> $stable(prescale_timer))
        else $error("prescale timer moved without a tick");
    bypass_pass_a: assert property (!cfg.div32_on && !cfg.div8_on |-> div8_tick == src_tick)
        else $error("bypassed prescalers did not pass the tick");
    merge_irq_a: assert property (clk_en |=> irq_q == |($past(req_now) & $past(cfg.irq_en)))
        else $error("shared request does not match enabled stage requests");
    mask_off_a: assert property (clk_en && cfg.irq_en == 6'h00 |=> !irq_q)
        else $error("request raised with all enables off");
    alarm_req_a: assert property (clk_en && alarm_hit |=> stage_req_q[RTC_REQ_ALARM])
        else $error("alarm request missing");
    reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0) sys_rst |=> count_all == 32'h0000_0000 && !irq_q)
        else $error("power reset did not clear the count");

    pre_wrap_c: cover property (clk_en && pre_ovf);
    s3_wrap_c: cover property (clk_en && s3_ovf);
    alarm_c: cover property (clk_en && alarm_hit && cfg.irq_en[RTC_REQ_ALARM]);
    pin_src_c: cover property (cfg.src_sel == RTC_SRC_PIN1 && pin_rise[1]);
endmodule

//--- src/rtc_pkg.sv
// Shared constants and carrier types for the real time clock divider chain
package rtc_pkg;
    localparam int unsigned RTC_PRE_W = 16;
    localparam int unsigned RTC_S0_W = 10;
    localparam int unsigned RTC_S1_W = 6;
    localparam int unsigned RTC_S2_W = 6;
    localparam int unsigned RTC_S3_W = 10;
    localparam int unsigned RTC_CNT_W = 32;
    localparam int unsigned RTC_HALF_W = 16;
    localparam int unsigned RTC_DIV32_W = 5;
    localparam int unsigned RTC_DIV8_W = 3;
    localparam int unsigned RTC_NREQ = 6;
    localparam int unsigned RTC_NPIN = 2;
    // Request vector bit positions
    localparam int unsigned RTC_REQ_PRE = 0;
    localparam int unsigned RTC_REQ_S0 = 1;
    localparam int unsigned RTC_REQ_S1 = 2;
    localparam int unsigned RTC_REQ_S2 = 3;
    localparam int unsigned RTC_REQ_S3 = 4;
    localparam int unsigned RTC_REQ_ALARM = 5;
    // Values after power reset
    localparam logic [RTC_DIV32_W-1:0] RTC_DIV32_RST = 5'h00;
    localparam logic [RTC_DIV8_W-1:0] RTC_DIV8_RST = 3'h0;
    localparam logic [RTC_NREQ-1:0] RTC_REQ_RST = 6'h00;
    localparam logic [RTC_NPIN-1:0] RTC_PIN_RST = 2'h0;
    localparam logic [RTC_HALF_W-1:0] RTC_HALF_RST = 16'h0000;

    typedef enum logic [1:0] {
        RTC_SRC_INT0 = 2'b00,
        RTC_SRC_INT1 = 2'b01,
        RTC_SRC_PIN0 = 2'b10,
        RTC_SRC_PIN1 = 2'b11
    } rtc_src_e;

    typedef struct packed {
        rtc_src_e src_sel;
        logic div32_on;
        logic div8_on;
        logic [RTC_PRE_W-1:0] pre_reload;
        logic [RTC_S0_W-1:0] s0_reload;
        logic [RTC_S1_W-1:0] s1_reload;
        logic [RTC_S2_W-1:0] s2_reload;
        logic [RTC_S3_W-1:0] s3_reload;
        logic [RTC_NREQ-1:0] irq_en;
        logic [RTC_CNT_W-1:0] alarm_value;
    } rtc_cfg_s;

    typedef struct packed {
        logic wr_pre;
        logic wr_low;
        logic wr_high;
        logic [RTC_HALF_W-1:0] wdata;
    } rtc_wr_s;
endpackage

//--- src/rtc_stage.sv
// One reloadable up-counting stage of the divider chain
`timescale 1ns/1ps
module rtc_stage #(
    parameter int unsigned W = 10
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic tick_in,
    input wire logic [W-1:0] reload,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] cnt_q,
    output logic ovf
);
    logic [W-1:0] cnt_d;
    logic at_top;

    // Overflow is the tick onward and the request, same cycle
    assign at_top = &cnt_q;
    assign ovf = tick_in & at_top;
    assign cnt_d = wr ? wdata : (ovf ? reload : cnt_q + {{(W-1){1'b0}}, 1'b1});

    // Counts up only, reloads on overflow, write takes priority
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (clk_en && (wr || tick_in)) begin
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- sim/rtc_chain_tb_top.sv
// Self-checking bench for the real time clock divider chain
`timescale 1ns/1ps
module rtc_chain_tb_top;
    import rtc_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic int_tick0 = 1'b0;
    logic int_tick1 = 1'b0;
    logic [RTC_NPIN-1:0] clk_pin = '0;
    rtc_cfg_s cfg = '0;
    rtc_wr_s wr = '0;
    logic [RTC_PRE_W-1:0] pre;
    logic [RTC_HALF_W-1:0] hi;
    logic [RTC_HALF_W-1:0] lo;
    logic [RTC_NREQ-1:0] req;
    logic irq;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;

    rtc_chain i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .int_tick0(int_tick0), .int_tick1(int_tick1), .clk_pin(clk_pin), .cfg(cfg),
        .wr(wr), .prescale_timer(pre), .count_high_word(hi), .count_low_word(lo),
        .stage_req_q(req), .irq_q(irq));

    // 250 MHz clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the run length
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic do_reset();
        @(negedge clk_sys);
        sys_rst = 1'b1;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
    endtask

    // Write strobe: 0 prescale timer, 1 low word, 2 high word
    task automatic write(input int sel, input logic [15:0] d);
        @(negedge clk_sys);
        wr.wr_pre = (sel == 0);
        wr.wr_low = (sel == 1);
        wr.wr_high = (sel == 2);
        wr.wdata = d;
        @(negedge clk_sys);
        wr = '0;
    endtask

    // Back-to-back ticks on one on-chip source
    task automatic ticks(input int n, input bit one = 1'b0);
        @(negedge clk_sys);
        if (one) begin
            int_tick1 = 1'b1;
        end else begin
            int_tick0 = 1'b1;
        end
        repeat (n) @(negedge clk_sys);
        int_tick0 = 1'b0;
        int_tick1 = 1'b0;
    endtask

    task automatic t_reset();
        write(0, 16'hA5C3);
        write(1, 16'h1234);
        write(2, 16'hBEEF);
        chk("pre", 32'h0000A5C3, pre);
        chk("lo", 32'h00001234, lo);
        chk("hi", 32'h0000BEEF, hi);
        do_reset();
        chk("rst cnt", 32'h0, {hi, lo});
        chk("rst pre", 32'h0, {9'h000, pre, req, irq});
    endtask

    task automatic t_overflow();
        cfg.pre_reload = 16'h8000;
        cfg.irq_en = 6'h01;
        write(0, 16'hFFFF);
        ticks(1);
        chk("pre", 32'h00008000, pre);
        chk("lo", 32'h00000001, lo);
        chk("req", 32'h01, req);
        chk("irq", 32'h1, irq);
        @(negedge clk_sys);
        chk("req drop", 32'h0, {req, irq});
        ticks(1);
        chk("pre up", 32'h00008001, pre);
        cfg.irq_en = 6'h00;
        write(0, 16'hFFFF);
        ticks(1);
        chk("masked", 32'h02, {req, irq});
    endtask

    task automatic t_cascade();
        cfg.s0_reload = 10'h005;
        cfg.s1_reload = 6'h2A;
        cfg.s2_reload = 6'h15;
        cfg.s3_reload = 10'h3C0;
        cfg.irq_en = 6'h10;
        write(0, 16'hFFFF);
        write(1, 16'h03FF);
        ticks(1);
        chk("lo", 32'h00000405, lo);
        chk("req", 32'h03, req);
        chk("irq", 32'h0, irq);
        write(0, 16'hFFFF);
        write(1, 16'hFFFF);
        write(2, 16'hFFFF);
        ticks(1);
        chk("count", {10'h3C0, 6'h15, 6'h2A, 10'h005}, {hi, lo});
        chk("req all", 32'h1F, req);
        chk("irq", 32'h1, irq);
    endtask

    task automatic t_alarm();
        cfg.pre_reload = 16'hFFFF;
        cfg.alarm_value = 32'h00000011;
        cfg.irq_en = 6'h20;
        write(0, 16'hFFFF);
        write(1, 16'h0010);
        write(2, 16'h0000);
        ticks(1);
        chk("alarm", 32'h43, {req, irq});
        ticks(1);
        chk("no alarm", 32'h02, {req, irq});
        chk("lo", 32'h00000012, lo);
    endtask

    task automatic t_divider();
        for (int m = 1; m < 4; m++) begin
            do_reset();
            cfg.div32_on = m[1];
            cfg.div8_on = m[0];
            ticks((m == 1) ? 7 : (m == 2) ? 31 : 255);
            chk("div short", 32'h0, pre);
            ticks(1);
            chk("div full", 32'h1, pre);
        end
        cfg.div32_on = 1'b0;
        cfg.div8_on = 1'b0;
    endtask

    task automatic t_source();
        write(0, 16'h1234);
        cfg.src_sel = RTC_SRC_INT1;
        ticks(1);
        chk("int0 off", 32'h1234, pre);
        ticks(1, 1'b1);
        chk("int1", 32'h1235, pre);
        for (int p = 0; p < 2; p++) begin
            cfg.src_sel = rtc_src_e'(2 + p);
            @(negedge clk_sys);
            clk_pin[p] = 1'b1;
            repeat (6) @(negedge clk_sys);
            chk("pin rise", 32'h1236 + p, pre);
            clk_pin[p] = 1'b0;
            repeat (6) @(negedge clk_sys);
            chk("pin fall", 32'h1236 + p, pre);
        end
        cfg.src_sel = RTC_SRC_INT0;
        clk_en = 1'b0;
        ticks(3);
        chk("frozen", 32'h1237, pre);
        clk_en = 1'b1;
    endtask

    initial begin
        do_reset();
        chk("init cnt", 32'h0, {hi, lo});
        chk("init pre", 32'h0, {9'h000, pre, req, irq});
        t_reset();
        t_overflow();
        t_cascade();
        t_alarm();
        t_divider();
        t_source();
        finish_test();
    end
endmodule
